//--- logic/rim_pkg.sv
// Package with register map, field positions, reset values and timing counts for the pin priority mux.
package rim_pkg;
    // Register indices; the APB byte address of each register is four times its index.
    localparam logic [7:0] IDX_CALIB = 8'h08;
    localparam logic [7:0] IDX_WDOG = 8'h09;
    localparam logic [7:0] IDX_ALARM1_MONTH = 8'h0A;
    localparam logic [7:0] IDX_FLAGS = 8'h0F;
    localparam logic [7:0] IDX_TIMER_CTRL = 8'h11;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [9:0] ADDR_CALIB = {IDX_CALIB, 2'b00};
    localparam logic [9:0] ADDR_WDOG = {IDX_WDOG, 2'b00};
    localparam logic [9:0] ADDR_ALARM1_MONTH = {IDX_ALARM1_MONTH, 2'b00};
    localparam logic [9:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
    localparam logic [9:0] ADDR_TIMER_CTRL = {IDX_TIMER_CTRL, 2'b00};
    localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    // Field positions.
    localparam int BIT_STATIC_LEVEL = 7;
    localparam int BIT_FREQ_TEST = 6;
    localparam int BIT_OSC_FAIL_IE = 7;
    localparam int BIT_ALARM1_IE = 7;
    localparam int BIT_BACKUP_IE = 5;
    localparam int BIT_TIMER_IE = 5;
    localparam int BIT_OSC_FAIL_FLAG = 2;
    // Power-on values of the control bytes.
    localparam logic [7:0] RST_CALIB = 8'h80;
    localparam logic [7:0] RST_WDOG = 8'h00;
    localparam logic [7:0] RST_ALARM1_MONTH = 8'h00;
    localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
    localparam logic RST_OSC_FAIL_FLAG = 1'b1;
    // Test tone: oscillator divided by 64, toggling every 32 oscillator cycles.
    localparam int OSC_DIV = 64;
    localparam logic [4:0] TONE_HALF_LAST = 5'h1F;
    // Pin selection states.
    typedef enum logic [3:0] {
        RIM_SEL_RELEASE = 4'b0001,
        RIM_SEL_LOW = 4'b0010,
        RIM_SEL_TONE = 4'b0100,
        RIM_SEL_IRQ = 4'b1000
    } rim_sel_e;
endpackage : rim_pkg

//--- logic/rim_pin_mux.sv
// Priority logic for the shared open-drain interrupt / test / level pin with APB control registers.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: One open-drain pin carries four interrupts, test tone, or static level.
// R2: Timer, oscillator fail, alarm 1 and watchdog are ORed into one request.
// R3: Frequency test puts a 512 Hz square wave on the pin.
// R4: Main supply uses all four sources; backup uses only alarm 1 and oscillator fail.
// R5: Main supply, level 0, test off: pin low whatever the interrupts.
// R6: Main supply, test on: tone when level is 0 or nothing enabled.
// R7: Main supply, level 1, source enabled: high until an enabled source asserts.
// R8: Main supply, level 1, test off, nothing enabled: pin high.
// R9: Static level is bit 7, test enable bit 6 of register 08h.
// R10: Alarm 1 enable bit 7, backup enable bit 5 of register 0Ah.
// R11: Oscillator fail enable bit 7 of 09h, timer enable bit 5 of 11h.
// R12: In backup the test tone is off and its enable ignored.
// R13: Backup with backup enable 0: pin released.
// R14: Backup, level 1, alarm 1 and oscillator fail disabled: pin released.
// R15: Backup, backup enable 1, level 0: pin low.
// R16: Backup interrupts drive pin only with level 1, backup enable 1, source enabled.
// R17: Host reads flags at 0Fh to find every pending source; the code holds only the oscillator fail flag there, at bit 2.
// R18: Further sources while low cause no extra transition.
// R19: Pin releases only after all asserted sources are cleared.
// R20: Oscillator fail clears only on a written 0; reads leave it.
// R21: Clearing its enable releases; re-enabling with flag set asserts at once.
// R22: The tone divides the 32.768 kHz oscillator by 64.
module rim_pin_mux (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic on_backup,
    input wire logic osc_tick,
    input wire logic timer_event,
    input wire logic alarm1_event,
    input wire logic watchdog_event,
    input wire logic watchdog_running,
    input wire logic osc_fail_event,
    input wire logic shared_irq_pin_in,
    output logic shared_irq_pin_out,
    output logic shared_irq_pin_oe
);
    logic [7:0] calib_r;
    logic [7:0] wdog_r;
    logic [7:0] alarm1_month_r;
    logic [7:0] timer_ctrl_r;
    logic osc_fail_flag_r;
    logic [4:0] tone_cnt_r;
    logic tone_r;
    logic pin_low_r;
    logic pin_low_nxt;
    rim_pkg::rim_sel_e sel;
    logic rd_ready_r;
    logic [3:0] src_live;
    logic [3:0] src_enable;
    logic [3:0] src_active;
    logic [3:0] src_armed;
    logic [3:0] src_pending;
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic static_level;
    logic freq_test_enable;
    logic backup_irq_enable;
    logic alarm1_irq_enable;
    logic osc_fail_irq_enable;
    logic timer_irq_enable;
    logic any_enabled;
    logic irq_request;

    // Writes finish in their first access cycle; a read waits until its data has been captured.
    assign pready = clk_en && (pwrite || rd_ready_r);
    assign wr_en = psel && penable && pwrite && clk_en;
    assign rd_en = psel && !pwrite && !rd_ready_r;

    // Read data is taken in the setup cycle, so it already stands when pready is sampled high.
    // A frozen clock enable only adds wait states; it never hands back stale data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ready_r <= 1'b0;
        end else if (clk_en) begin
            if (psel && penable && pready) begin
                rd_ready_r <= 1'b0;
            end else if (psel && !pwrite) begin
                rd_ready_r <= 1'b1;
            end
        end
    end

    // Field views of the control bytes.
    assign static_level = calib_r[rim_pkg::BIT_STATIC_LEVEL]; // R9
    assign freq_test_enable = calib_r[rim_pkg::BIT_FREQ_TEST]; // R9
    assign alarm1_irq_enable = alarm1_month_r[rim_pkg::BIT_ALARM1_IE]; // R10
    assign backup_irq_enable = alarm1_month_r[rim_pkg::BIT_BACKUP_IE]; // R10
    assign osc_fail_irq_enable = wdog_r[rim_pkg::BIT_OSC_FAIL_IE]; // R11
    assign timer_irq_enable = timer_ctrl_r[rim_pkg::BIT_TIMER_IE]; // R11

    // Address decode for the error answer.
    always_comb begin
        if (paddr == rim_pkg::ADDR_CALIB) begin
            addr_hit = 1'b1;
        end else if (paddr == rim_pkg::ADDR_WDOG) begin
            addr_hit = 1'b1;
        end else if (paddr == rim_pkg::ADDR_ALARM1_MONTH) begin
            addr_hit = 1'b1;
        end else if (paddr == rim_pkg::ADDR_FLAGS) begin
            addr_hit = 1'b1;
        end else if (paddr == rim_pkg::ADDR_TIMER_CTRL) begin
            addr_hit = 1'b1;
        end else if (paddr == rim_pkg::ADDR_STATUS) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    end
    assign pslverr = psel && penable && !addr_hit;

    // Control byte writes; only byte lane 0 carries data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calib_r <= rim_pkg::RST_CALIB;
            wdog_r <= rim_pkg::RST_WDOG;
            alarm1_month_r <= rim_pkg::RST_ALARM1_MONTH;
            timer_ctrl_r <= rim_pkg::RST_TIMER_CTRL;
        end else if (wr_en && pstrb[0]) begin
            if (paddr == rim_pkg::ADDR_CALIB) begin
                calib_r <= pwdata[7:0]; // R9
            end else if (paddr == rim_pkg::ADDR_WDOG) begin
                wdog_r <= pwdata[7:0]; // R11
            end else if (paddr == rim_pkg::ADDR_ALARM1_MONTH) begin
                alarm1_month_r <= pwdata[7:0]; // R10
            end else if (paddr == rim_pkg::ADDR_TIMER_CTRL) begin
                timer_ctrl_r <= pwdata[7:0]; // R11
            end
        end
    end

    // Oscillator fail flag: a new failure beats a simultaneous software clear, so nothing is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_fail_flag_r <= rim_pkg::RST_OSC_FAIL_FLAG;
        end else if (clk_en) begin
            if (osc_fail_event) begin
                osc_fail_flag_r <= 1'b1;
            end else if (wr_en && pstrb[0] && paddr == rim_pkg::ADDR_FLAGS &&
                         !pwdata[rim_pkg::BIT_OSC_FAIL_FLAG]) begin
                osc_fail_flag_r <= 1'b0; // R20
            end
        end
    end

    // Read mux; reads have no side effects on any flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (!rd_en || !psel) begin
                prdata <= prdata;
            end else if (paddr == rim_pkg::ADDR_CALIB) begin
                prdata <= {24'h00_0000, calib_r};
            end else if (paddr == rim_pkg::ADDR_WDOG) begin
                prdata <= {24'h00_0000, wdog_r};
            end else if (paddr == rim_pkg::ADDR_ALARM1_MONTH) begin
                prdata <= {24'h00_0000, alarm1_month_r};
            end else if (paddr == rim_pkg::ADDR_FLAGS) begin
                prdata <= {29'h0000_0000, osc_fail_flag_r, 2'b00}; // R20
            end else if (paddr == rim_pkg::ADDR_TIMER_CTRL) begin
                prdata <= {24'h00_0000, timer_ctrl_r};
            end else if (paddr == rim_pkg::ADDR_STATUS) begin
                prdata <= {26'h000_0000, shared_irq_pin_in, on_backup, irq_request, tone_r, pin_low_r,
                           any_enabled};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Tone divider: toggling every 32 oscillator ticks gives 64 ticks per period, 50 percent duty.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_cnt_r <= 5'h00;
            tone_r <= 1'b0;
        end else if (clk_en && osc_tick) begin
            tone_cnt_r <= tone_cnt_r + 5'h01; // R22
            if (tone_cnt_r == rim_pkg::TONE_HALF_LAST) begin
                tone_r <= !tone_r; // R3
            end
        end
    end

    // Per-source gating; backup masks timer and watchdog, which have no battery supply.
    // Bit order of the source vectors: alarm 1, oscillator fail, timer, watchdog.
    assign src_live = {!on_backup, !on_backup, 2'b11}; // R4
    assign src_enable = {watchdog_running, timer_irq_enable, osc_fail_irq_enable, alarm1_irq_enable}; // R2
    assign src_active = {watchdog_event, timer_event, osc_fail_flag_r, alarm1_event}; // R19
    for (genvar i = 0; i < 4; i++) begin : g_src
        assign src_armed[i] = src_live[i] && src_enable[i]; // R4
        assign src_pending[i] = src_armed[i] && src_active[i]; // R21
    end

    // Level OR of the armed sources, so a later source cannot add an edge while the pin is low.
    assign any_enabled = |src_armed; // R2
    assign irq_request = |src_pending; // R2 R18

    // Priority selection of what the pin carries.
    always_comb begin
        if (on_backup) begin
            if (!backup_irq_enable) begin
                sel = rim_pkg::RIM_SEL_RELEASE; // R13 R12
            end else if (!static_level) begin
                sel = rim_pkg::RIM_SEL_LOW; // R15
            end else if (!any_enabled) begin
                sel = rim_pkg::RIM_SEL_RELEASE; // R14
            end else begin
                sel = rim_pkg::RIM_SEL_IRQ; // R16
            end
        end else begin
            if (!static_level && !freq_test_enable) begin
                sel = rim_pkg::RIM_SEL_LOW; // R5
            end else if (freq_test_enable && (!static_level || !any_enabled)) begin
                sel = rim_pkg::RIM_SEL_TONE; // R6
            end else if (any_enabled) begin
                sel = rim_pkg::RIM_SEL_IRQ; // R7
            end else begin
                sel = rim_pkg::RIM_SEL_RELEASE; // R8
            end
        end
    end

    // Next pin level; the request is a level OR, so added sources leave the pin where it is.
    always_comb begin
        case (sel)
            rim_pkg::RIM_SEL_LOW: pin_low_nxt = 1'b1;
            rim_pkg::RIM_SEL_TONE: pin_low_nxt = !tone_r;
            rim_pkg::RIM_SEL_IRQ: pin_low_nxt = irq_request; // R18 R19
            default: pin_low_nxt = 1'b0;
        endcase
    end

    // Registered pin drive avoids glitches when several control bits change in one write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_low_r <= 1'b0;
        end else if (clk_en) begin
            pin_low_r <= pin_low_nxt;
        end
    end

    // Open drain: drive zero only, enable when pulling low.
    assign shared_irq_pin_out = 1'b0; // R1
    assign shared_irq_pin_oe = pin_low_r; // R1

    // Level 0 with the test off overrides every interrupt on main supply.
    a_main_low_level: assert property (@(posedge pclk) disable iff (!presetn) // R5
        clk_en && !on_backup && !static_level && !freq_test_enable |=> shared_irq_pin_oe)
        else $error("pin not low for level 0 on main supply");

    // Without the backup enable nothing may pull the pin on battery.
    a_backup_release: assert property (@(posedge pclk) disable iff (!presetn) // R13
        clk_en && on_backup && !backup_irq_enable |=> !shared_irq_pin_oe)
        else $error("pin driven in backup without backup enable");

    // Level 0 dominates in backup once the backup enable is set.
    a_backup_low: assert property (@(posedge pclk) disable iff (!presetn) // R15
        clk_en && on_backup && backup_irq_enable && !static_level |=> shared_irq_pin_oe)
        else $error("pin not low in backup with level 0");

    // With no battery source enabled the pin must stay released.
    a_backup_no_src: assert property (@(posedge pclk) disable iff (!presetn) // R14
        clk_en && on_backup && static_level && !alarm1_irq_enable && !osc_fail_irq_enable
        |=> !shared_irq_pin_oe)
        else $error("pin driven in backup with no source enabled");

    // Timer and watchdog lose power in backup, so they must never reach the pin there.
    a_backup_timer_off: assert property (@(posedge pclk) disable iff (!presetn) // R4
        clk_en && on_backup && static_level && !(alarm1_irq_enable && alarm1_event) &&
        !(osc_fail_irq_enable && osc_fail_flag_r) |=> !shared_irq_pin_oe)
        else $error("timer or watchdog drove pin in backup");

    // Nothing enabled and no test: the pull-up wins.
    a_idle_high: assert property (@(posedge pclk) disable iff (!presetn) // R8
        clk_en && !on_backup && static_level && !freq_test_enable && !any_enabled
        |=> !shared_irq_pin_oe)
        else $error("pin driven with nothing enabled");

    // An unserviced oscillator failure must show as soon as its enable is set.
    a_osc_fail_irq: assert property (@(posedge pclk) disable iff (!presetn) // R21
        clk_en && static_level && !freq_test_enable && osc_fail_irq_enable && osc_fail_flag_r &&
        (!on_backup || backup_irq_enable) |=> shared_irq_pin_oe)
        else $error("oscillator fail did not assert pin");

    // Only a written 0 may clear the failure flag; reads must leave it alone.
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R20
        osc_fail_flag_r && !(wr_en && paddr == rim_pkg::ADDR_FLAGS) |=> osc_fail_flag_r)
        else $error("oscillator fail flag cleared without write");

    // All sources serviced: the pin has to let go.
    a_irq_release: assert property (@(posedge pclk) disable iff (!presetn) // R19
        clk_en && !on_backup && static_level && any_enabled && !irq_request |=> !shared_irq_pin_oe)
        else $error("pin held low with no request");

    // Level 0 with the test on hands the pin to the tone.
    a_tone_follow: assert property (@(posedge pclk) disable iff (!presetn) // R6
        clk_en && !on_backup && freq_test_enable && !static_level |=> shared_irq_pin_oe == !$past(tone_r))
        else $error("pin does not follow test tone");

    // With nothing enabled the tone also wins at level 1.
    a_tone_level1: assert property (@(posedge pclk) disable iff (!presetn) // R6
        clk_en && !on_backup && freq_test_enable && static_level && !any_enabled
        |=> shared_irq_pin_oe == !$past(tone_r))
        else $error("pin does not follow tone with nothing enabled");

    // An enabled request pulls the pin low whatever the test bit says.
    a_main_irq_low: assert property (@(posedge pclk) disable iff (!presetn) // R7
        clk_en && !on_backup && static_level && irq_request |=> shared_irq_pin_oe)
        else $error("enabled request did not pull pin low");

    // A low pin stays low while any request remains, however many sources join.
    a_irq_hold: assert property (@(posedge pclk) disable iff (!presetn) // R18
        clk_en && shared_irq_pin_oe && sel == rim_pkg::RIM_SEL_IRQ && irq_request |=> shared_irq_pin_oe)
        else $error("pin rose while a request was pending");

    // On battery with level 1 and the backup enable, the pin follows the battery sources only.
    a_backup_irq: assert property (@(posedge pclk) disable iff (!presetn) // R16
        clk_en && on_backup && backup_irq_enable && static_level
        |=> shared_irq_pin_oe == $past(irq_request))
        else $error("pin does not follow backup request");

    // The test bit is a don't-care on battery.
    a_backup_no_tone: assert property (@(posedge pclk) disable iff (!presetn) // R12
        on_backup |-> sel != rim_pkg::RIM_SEL_TONE)
        else $error("tone selected in backup");

    // A written 0 clears the flag unless a new failure arrives in the same cycle.
    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // R20
        wr_en && pstrb[0] && paddr == rim_pkg::ADDR_FLAGS && !pwdata[rim_pkg::BIT_OSC_FAIL_FLAG] &&
        !osc_fail_event |=> !osc_fail_flag_r)
        else $error("written 0 did not clear oscillator fail flag");

    // A failure always sets the flag, even against a clear in the same cycle.
    a_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // R20
        clk_en && osc_fail_event |=> osc_fail_flag_r)
        else $error("oscillator fail event lost");

    // The tone flips on the last tick of each half period and at no other time.
    a_tone_toggle: assert property (@(posedge pclk) disable iff (!presetn) // R22
        clk_en && osc_tick && tone_cnt_r == rim_pkg::TONE_HALF_LAST |=> tone_r != $past(tone_r))
        else $error("tone did not toggle at end of half period");
    a_tone_hold: assert property (@(posedge pclk) disable iff (!presetn) // R22
        !(clk_en && osc_tick && tone_cnt_r == rim_pkg::TONE_HALF_LAST) |=> tone_r == $past(tone_r))
        else $error("tone toggled early");

    // A read completes in the cycle after its setup unless the clock enable is low.
    a_read_ready: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable && !pwrite |=> pready || !clk_en)
        else $error("read not ready after setup");

    c_tone: cover property (@(posedge pclk) disable iff (!presetn) sel == rim_pkg::RIM_SEL_TONE && $rose(tone_r));
    c_irq_main: cover property (@(posedge pclk) disable iff (!presetn) !on_backup && $rose(shared_irq_pin_oe) &&
        sel == rim_pkg::RIM_SEL_IRQ);
    c_irq_backup: cover property (@(posedge pclk) disable iff (!presetn) on_backup && shared_irq_pin_oe &&
        sel == rim_pkg::RIM_SEL_IRQ);
    c_flag_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(osc_fail_flag_r));
    c_read_done: cover property (@(posedge pclk) disable iff (!presetn) psel && penable && !pwrite && pready);
endmodule : rim_pin_mux
`default_nettype wire

//--- testbench/rim_host_model.sv
// Host processor model: APB master, pin pull-up and interrupt service.
`timescale 1ns/100ps
`default_nettype none
module rim_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [9:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    // The board pull-up sets the released level; only the device pulls low.
    assign pin_level = pin_oe ? pin_out : 1'b1;
    // Bus idle at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0000_0000;
    end
    // Called just after an edge; request held until pready is sampled high.
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        e = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next request from reassigning psel in this time step.
        @(posedge pclk);
    endtask : xfer
    // Service reads the flags first, since several sources may be pending.
    task automatic service();
        logic [31:0] q;
        logic e;
        xfer(1'b0, rim_pkg::ADDR_FLAGS, 32'h0, q, e);
        if (q[rim_pkg::BIT_OSC_FAIL_FLAG] === 1'b1) xfer(1'b1, rim_pkg::ADDR_FLAGS, 32'h0, q, e);
    endtask : service
endmodule : rim_host_model
`default_nettype wire

//--- testbench/rim_pin_mux_tb_top.sv
// Self-checking testbench for the shared interrupt pin priority mux.
`timescale 1ns/100ps
`default_nettype none
`define RIM_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module rim_pin_mux_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic on_backup = 1'b0, osc_tick = 1'b0, timer_event = 1'b0, alarm1_event = 1'b0;
    logic watchdog_event = 1'b0, watchdog_running = 1'b0, osc_fail_event = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pin_out, pin_oe, pin_level;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic e;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    rim_pin_mux dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .on_backup(on_backup), .osc_tick(osc_tick), .timer_event(timer_event),
        .alarm1_event(alarm1_event), .watchdog_event(watchdog_event), .watchdog_running(watchdog_running),
        .osc_fail_event(osc_fail_event), .shared_irq_pin_in(pin_level), .shared_irq_pin_out(pin_out),
        .shared_irq_pin_oe(pin_oe));
    rim_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level(pin_level));
    // A 100 ns clock.
    initial begin
        forever #50 pclk = ~pclk;
    end
    // Each scenario starts from reset so that no setting leaks into the next.
    task automatic rst();
        @(posedge pclk);
        {on_backup, osc_tick, timer_event, alarm1_event} <= 4'h0;
        {watchdog_event, watchdog_running, osc_fail_event} <= 3'h0;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : rst
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, q, e);
    endtask : wr
    // Register update plus one pin edge must have landed before looking.
    task automatic pin(input logic ex);
        repeat (2) @(posedge pclk);
        `RIM_CHK("pin_oe", ex, pin_oe)
    endtask : pin
    // Counts pin toggles over 256 cycles with a tick every cycle.
    task automatic toggles(output int c);
        logic p;
        c = 0;
        osc_tick <= 1'b1;
        @(posedge pclk);
        p = pin_oe;
        repeat (256) begin
            @(posedge pclk);
            if (pin_oe !== p) c++;
            p = pin_oe;
        end
        osc_tick <= 1'b0;
    endtask : toggles
    task automatic t_regs();
        rst();
        pin(1'b0);
        wr(rim_pkg::ADDR_CALIB, 8'hC0);
        host.xfer(1'b0, rim_pkg::ADDR_CALIB, 32'h0, q, e);
        `RIM_CHK("calib", 32'h0000_00C0, q)
        wr(rim_pkg::ADDR_ALARM1_MONTH, 8'hA0);
        host.xfer(1'b0, rim_pkg::ADDR_ALARM1_MONTH, 32'h0, q, e);
        `RIM_CHK("alarm1_month", 32'h0000_00A0, q)
        wr(rim_pkg::ADDR_TIMER_CTRL, 8'h20);
        host.xfer(1'b0, rim_pkg::ADDR_TIMER_CTRL, 32'h0, q, e);
        `RIM_CHK("timer_ctrl", 32'h0000_0020, q)
        host.xfer(1'b0, 10'h3FC, 32'h0, q, e);
        `RIM_CHK("unmapped_err", 1'b1, e)
    endtask : t_regs
    task automatic t_main();
        rst();
        alarm1_event <= 1'b1;
        wr(rim_pkg::ADDR_ALARM1_MONTH, 8'h80);
        wr(rim_pkg::ADDR_CALIB, 8'h00);
        pin(1'b1);
        `RIM_CHK("pin_level", 1'b0, pin_level)
        for (int i = 0; i < 2; i++) begin
            rst();
            wr(rim_pkg::ADDR_CALIB, i ? 8'hC0 : 8'h40);
            toggles(n);
            `RIM_CHK("tone_edges", 7, n)
        end
        rst();
        wr(rim_pkg::ADDR_TIMER_CTRL, 8'h20);
        pin(1'b0);
        timer_event <= 1'b1;
        watchdog_running <= 1'b1;
        pin(1'b1);
        watchdog_event <= 1'b1;
        pin(1'b1);
        timer_event <= 1'b0;
        pin(1'b1);
        watchdog_event <= 1'b0;
        pin(1'b0);
        // A low clock enable must hold the pin whatever the sources do.
        clk_en <= 1'b0;
        timer_event <= 1'b1;
        pin(1'b0);
        clk_en <= 1'b1;
        pin(1'b1);
    endtask : t_main
    task automatic t_osc();
        rst();
        wr(rim_pkg::ADDR_WDOG, 8'h80);
        pin(1'b1);
        host.xfer(1'b0, rim_pkg::ADDR_FLAGS, 32'h0, q, e);
        `RIM_CHK("osc_flag", 1'b1, q[rim_pkg::BIT_OSC_FAIL_FLAG])
        pin(1'b1);
        wr(rim_pkg::ADDR_WDOG, 8'h00);
        pin(1'b0);
        wr(rim_pkg::ADDR_WDOG, 8'h80);
        pin(1'b1);
        host.service();
        pin(1'b0);
        osc_fail_event <= 1'b1;
        @(posedge pclk);
        osc_fail_event <= 1'b0;
        pin(1'b1);
    endtask : t_osc
    task automatic t_backup();
        rst();
        on_backup <= 1'b1;
        wr(rim_pkg::ADDR_CALIB, 8'h00);
        pin(1'b0);
        wr(rim_pkg::ADDR_ALARM1_MONTH, 8'h20);
        pin(1'b1);
        wr(rim_pkg::ADDR_CALIB, 8'hC0);
        toggles(n);
        `RIM_CHK("backup_tone_edges", 0, n)
        `RIM_CHK("backup_pin", 1'b0, pin_oe)
        wr(rim_pkg::ADDR_TIMER_CTRL, 8'h20);
        {timer_event, watchdog_event, watchdog_running} <= 3'h7;
        pin(1'b0);
        wr(rim_pkg::ADDR_ALARM1_MONTH, 8'hA0);
        pin(1'b0);
        alarm1_event <= 1'b1;
        pin(1'b1);
    endtask : t_backup
    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // Main sequence.
    initial begin
        t_regs();
        t_main();
        t_osc();
        t_backup();
        stop_test();
    end
    // The whole run needs about a thousand cycles; twenty thousand means a hang.
    initial begin
        #2000000;
        num_errors++;
        stop_test();
    end
endmodule : rim_pin_mux_tb_top
`default_nettype wire
